// ===== hdl/mapsw_pkg.sv
// map-switch control constants, chip select carrier and state encoding
// assumes one 100 MHz clock; mcu bus cycles marked by a one-cycle strobe
// Functional notes
// - decode monitor and user 64K maps; exactly one active per cycle
// - temporary switch: fetches in monitor, one data cycle in user map
// - after that one user cycle, back to monitor map unprompted
// - permanent switch: trap-return fetched in monitor, then user map
// - user reset: reset mcu and ports, select user map, ignore breakpoints until first fetch
// - trap fetch from breakpoint or abort returns to monitor after stacking
// - plain user trap without breakpoint or abort keeps user map
// - abort injects trap opcode on data bus at fetch, then monitor map
// - abort ignored while monitor map is active
// - init register writes blocked 64 bus cycles after reset
// - late init register write is ignored; address stays internal, no chip select
// - hold init register copy; compare to top address nibble
// - chip select for every board memory and peripheral
// - family select chooses between two map layouts
// - internal ram and register block get no external chip select
// - user pseudo-rom is write protected while user code runs
package mapsw_pkg;
   localparam logic [7:0]  SOFT_TRAP_OPCODE   = 8'h3f;
   localparam logic [7:0]  TRAP_RETURN_OPCODE = 8'h3b;
   localparam logic [6:0]  INIT_TIMEOUT_CYC   = 7'h40;
   localparam logic [3:0]  OPERAND_CYC        = 4'h2;
   localparam logic [3:0]  STACK_CYC          = 4'hc;
   localparam logic [15:0] INIT_REG_OFFS      = 16'h003d;
   localparam logic [7:0]  INIT_RESET_VAL     = 8'h01;
   localparam logic [15:0] DUART_LO     = 16'ha200;
   localparam logic [15:0] DUART_HI     = 16'ha20f;
   localparam logic [15:0] SCRATCH_LO   = 16'hb400;
   localparam logic [15:0] SCRATCH_HI   = 16'hb5ff;
   localparam logic [15:0] EPROM_LO     = 16'hc000;
   localparam logic [15:0] EPROM_HI     = 16'hffff;
   localparam logic [15:0] PSEUDO_EE_LO = 16'hb600;
   localparam logic [15:0] PSEUDO_EE_HI = 16'hb7ff;
   localparam logic [15:0] PROM1_LO     = 16'hc000;
   localparam logic [15:0] PROM1_HI     = 16'hdfff;
   localparam logic [15:0] PROM2_LO     = 16'he000;
   localparam logic [15:0] PROM2_HI     = 16'hffff;

   typedef struct packed {
      logic duart;
      logic scratch;
      logic eprom;
      logic pseudo_ee;
      logic prom1;
      logic prom2;
   } cs_t;

   typedef enum logic [5:0] {
      ST_MON    = 6'b000001,
      ST_T_ARM  = 6'b000010,
      ST_T_OPER = 6'b000100,
      ST_T_USER = 6'b001000,
      ST_USER   = 6'b010000,
      ST_RETURN = 6'b100000
   } map_st_t;
endpackage

// ===== hdl/map_decoder.sv
// address decoder: chip selects for the active map and family layout
// assumes address, direction and map are stable for the cycle decoded
`timescale 1ns/1ps
module map_decoder (
   // bus cycle
   input  wire logic                  i_user_map,
   input  wire logic                  i_family_ex,
   input  wire logic                  i_write,
   input  wire logic                  i_rom_wp,
   input  wire logic [15:0]           i_addr,
   input  wire logic [7:0]            i_init_val,
   // decode results
   output mapsw_pkg::cs_t             o_cs,
   output logic                       o_internal
);
   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   logic int_reg;
   logic int_ram;
   logic rom_blk;

   // registers in low nibble 4K page, ram in high nibble page
   assign int_reg = (i_addr[15:12] == i_init_val[3:0]) &&
                    (i_addr[11:6] == 6'h00);
   assign int_ram = (i_addr[15:12] == i_init_val[7:4]) &&
                    (i_addr[11:8] == 4'h0);
   assign o_internal = int_reg | int_ram;
   assign rom_blk = i_write & i_rom_wp;

   always_comb begin
      o_cs = '0;
      if (o_internal) begin
         o_cs = '0;
      end else if (!i_user_map) begin
         o_cs.duart   = in_rng(i_addr, mapsw_pkg::DUART_LO,
                               mapsw_pkg::DUART_HI);
         o_cs.scratch = in_rng(i_addr, mapsw_pkg::SCRATCH_LO,
                               mapsw_pkg::SCRATCH_HI);
         o_cs.eprom   = in_rng(i_addr, mapsw_pkg::EPROM_LO,
                               mapsw_pkg::EPROM_HI);
      end else begin
         o_cs.pseudo_ee = in_rng(i_addr, mapsw_pkg::PSEUDO_EE_LO,
                                 mapsw_pkg::PSEUDO_EE_HI);
         o_cs.prom1 = i_family_ex & ~rom_blk &
                      in_rng(i_addr, mapsw_pkg::PROM1_LO,
                             mapsw_pkg::PROM1_HI);
         o_cs.prom2 = ~rom_blk &
                      in_rng(i_addr, mapsw_pkg::PROM2_LO,
                             mapsw_pkg::PROM2_HI);
      end
   end
endmodule // map_decoder

// ===== hdl/map_switch_ctrl.sv
// monitor/user map switching, abort trap injection, init write timeout
// assumes bus inputs are synchronous to i_clk_sys; buttons are raw pins
`timescale 1ns/1ps
module map_switch_ctrl (
   // clock and reset
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_nrst,
   // mcu bus
   input  wire logic                  i_bus_cyc,
   input  wire logic                  i_instruction_fetch_strobe,
   input  wire logic                  i_write,
   input  wire logic [15:0]           i_addr,
   input  wire logic [7:0]            i_data,
   // monitor commands and board straps
   input  wire logic                  i_temp_switch,
   input  wire logic                  i_perm_switch,
   input  wire logic                  i_brk_armed,
   input  wire logic                  i_family_map_select,
   // pushbuttons, raw
   input  wire logic                  i_abort_pushbutton,
   input  wire logic                  i_user_reset_pushbutton,
   // outputs
   output logic                       o_user_map_q,
   output mapsw_pkg::cs_t             o_cs_q,
   output logic                       o_internal_q,
   output logic                       o_mcu_rst_n_q,
   output logic                       o_init_wp_q,
   output logic [7:0]                 o_init_val_q,
   output logic [7:0]                 o_data_q,
   output logic                       o_data_oe_n_q
);
   mapsw_pkg::map_st_t st_q;
   mapsw_pkg::map_st_t st_d;
   logic [2:0] abort_sync_q;
   logic [2:0] ureset_sync_q;
   logic       abort_lvl_q;
   logic       ureset_lvl_q;
   logic       abort_pend_q;
   logic       ign_brk_q;
   logic [3:0] cnt_q;
   logic [6:0] init_cnt_q;
   logic       trap_fetch;
   logic       trap_return;
   mapsw_pkg::cs_t cs_w;
   logic       internal_w;

   function automatic logic user_state(input mapsw_pkg::map_st_t s);
      user_state = (s == mapsw_pkg::ST_T_USER) ||
                   (s == mapsw_pkg::ST_USER)   ||
                   (s == mapsw_pkg::ST_RETURN);
   endfunction

   // button synchronisers; level changes only when stages 2 and 3 agree
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         abort_sync_q  <= 3'h0;
         ureset_sync_q <= 3'h0;
         abort_lvl_q   <= 1'b0;
         ureset_lvl_q  <= 1'b0;
      end else begin
         abort_sync_q  <= {abort_sync_q[1:0], i_abort_pushbutton};
         ureset_sync_q <= {ureset_sync_q[1:0], i_user_reset_pushbutton};
         if (abort_sync_q[1] == abort_sync_q[2])
            abort_lvl_q <= abort_sync_q[2];
         if (ureset_sync_q[1] == ureset_sync_q[2])
            ureset_lvl_q <= ureset_sync_q[2];
      end
   end

   // trap seen at fetch: breakpoint (unless ignored) or abort
   assign trap_fetch = i_bus_cyc & i_instruction_fetch_strobe &
                       (i_data == mapsw_pkg::SOFT_TRAP_OPCODE) &
                       ((i_brk_armed & ~ign_brk_q) | abort_pend_q);
   assign trap_return = i_bus_cyc & i_instruction_fetch_strobe &
                        (i_data == mapsw_pkg::TRAP_RETURN_OPCODE);

   always_comb begin
      st_d = st_q;
      if (ureset_lvl_q) begin
         st_d = mapsw_pkg::ST_USER;
      end else begin
         case (st_q)
            mapsw_pkg::ST_MON: begin
               if (i_perm_switch)
                  st_d = mapsw_pkg::ST_USER;
               else if (i_temp_switch)
                  st_d = mapsw_pkg::ST_T_ARM;
            end
            mapsw_pkg::ST_T_ARM: begin
               if (i_bus_cyc && i_instruction_fetch_strobe)
                  st_d = mapsw_pkg::ST_T_OPER;
            end
            mapsw_pkg::ST_T_OPER: begin
               if (i_bus_cyc && cnt_q == mapsw_pkg::OPERAND_CYC - 4'h1)
                  st_d = mapsw_pkg::ST_T_USER;
            end
            mapsw_pkg::ST_T_USER: begin
               if (i_bus_cyc)
                  st_d = mapsw_pkg::ST_MON;
            end
            mapsw_pkg::ST_USER: begin
               if (trap_fetch)
                  st_d = mapsw_pkg::ST_RETURN;
            end
            mapsw_pkg::ST_RETURN: begin
               if (i_bus_cyc && cnt_q == mapsw_pkg::STACK_CYC - 4'h1)
                  st_d = mapsw_pkg::ST_MON;
            end
            default: st_d = mapsw_pkg::ST_MON;
         endcase
      end
   end

   // permanent switch waits in monitor for the trap-return fetch
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q         <= mapsw_pkg::ST_MON;
         o_user_map_q <= 1'b0;
      end else if (st_q == mapsw_pkg::ST_MON && i_perm_switch &&
                   !ureset_lvl_q && !trap_return) begin
         st_q         <= mapsw_pkg::ST_MON;
         o_user_map_q <= 1'b0;
      end else begin
         st_q         <= st_d;
         o_user_map_q <= user_state(st_d);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst)
         cnt_q <= 4'h0;
      else if (st_d != st_q)
         cnt_q <= 4'h0;
      else if (i_bus_cyc)
         cnt_q <= cnt_q + 4'h1;
   end

   // reset pulse to mcu and ports; breakpoints ignored until first fetch
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mcu_rst_n_q <= 1'b0;
         ign_brk_q     <= 1'b0;
      end else begin
         o_mcu_rst_n_q <= ~ureset_lvl_q;
         if (ureset_lvl_q)
            ign_brk_q <= 1'b1;
         else if (i_bus_cyc && i_instruction_fetch_strobe)
            ign_brk_q <= 1'b0;
      end
   end

   // abort: latch in user map only, drive trap once at next fetch
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         abort_pend_q  <= 1'b0;
         o_data_oe_n_q <= 1'b1;
         o_data_q      <= 8'h00;
      end else begin
         if (abort_pend_q && i_bus_cyc && i_instruction_fetch_strobe)
            abort_pend_q <= 1'b0;
         else if (abort_lvl_q && st_q == mapsw_pkg::ST_USER)
            abort_pend_q <= 1'b1;
         o_data_q <= mapsw_pkg::SOFT_TRAP_OPCODE;
         if (i_bus_cyc)
            o_data_oe_n_q <= 1'b1;
         else if (abort_pend_q && i_instruction_fetch_strobe)
            o_data_oe_n_q <= 1'b0;
      end
   end

   // init register write window, counted in bus cycles
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         init_cnt_q   <= 7'h00;
         o_init_wp_q  <= 1'b0;
         o_init_val_q <= mapsw_pkg::INIT_RESET_VAL;
      end else begin
         if (ureset_lvl_q) begin
            init_cnt_q  <= 7'h00;
            o_init_wp_q <= 1'b0;
         end else if (i_bus_cyc && !o_init_wp_q) begin
            init_cnt_q <= init_cnt_q + 7'h01;
            if (init_cnt_q == mapsw_pkg::INIT_TIMEOUT_CYC - 7'h01)
               o_init_wp_q <= 1'b1;
         end
         if (i_bus_cyc && i_write && !o_init_wp_q &&
             i_addr == ({o_init_val_q[3:0], 12'h000} |
                        mapsw_pkg::INIT_REG_OFFS))
            o_init_val_q <= i_data;
      end
   end

   map_decoder u_dec (
      .i_user_map  (o_user_map_q),
      .i_family_ex (i_family_map_select),
      .i_write     (i_write),
      .i_rom_wp    (st_q == mapsw_pkg::ST_USER),
      .i_addr      (i_addr),
      .i_init_val  (o_init_val_q),
      .o_cs        (cs_w),
      .o_internal  (internal_w)
   );

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cs_q       <= '0;
         o_internal_q <= 1'b0;
      end else begin
         o_cs_q       <= cs_w;
         o_internal_q <= internal_w;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   sequence s_temp_user;
      st_q == mapsw_pkg::ST_T_USER && i_bus_cyc && !ureset_lvl_q;
   endsequence

   a_temp_return: assert property (s_temp_user |=> !o_user_map_q)
      else $error("temporary user cycle did not return to monitor");
   a_temp_enter: assert property (st_q == mapsw_pkg::ST_T_OPER &&
      i_bus_cyc && cnt_q == 4'h1 && !ureset_lvl_q |=> o_user_map_q)
      else $error("temporary switch did not reach user map");
   // chip selects lag the map by one clock, hence the past value
   a_map_one: assert property ($past(o_user_map_q) ?
      !o_cs_q.duart && !o_cs_q.scratch && !o_cs_q.eprom :
      !o_cs_q.pseudo_ee && !o_cs_q.prom1 && !o_cs_q.prom2)
      else $error("chip select from the inactive map");
   a_reset_user: assert property (ureset_lvl_q |=>
      o_user_map_q && !o_mcu_rst_n_q)
      else $error("user reset did not select user map");
   a_plain_trap: assert property (st_q == mapsw_pkg::ST_USER &&
      !i_brk_armed && !abort_pend_q && !ureset_lvl_q |=>
      o_user_map_q)
      else $error("plain user trap left user map");
   a_abort_mon: assert property (st_q != mapsw_pkg::ST_USER &&
      !abort_pend_q |=> !abort_pend_q)
      else $error("abort latched outside user map");
   a_inject_fetch: assert property ($fell(o_data_oe_n_q) |->
      $past(abort_pend_q) && $past(i_instruction_fetch_strobe))
      else $error("trap driven outside an abort fetch");
   a_init_lock: assert property (o_init_wp_q && !ureset_lvl_q |=>
      $stable(o_init_val_q))
      else $error("init copy changed after timeout");
   a_int_nocs: assert property (o_internal_q |-> o_cs_q == '0)
      else $error("chip select over internal area");
   a_rom_wp: assert property (st_q == mapsw_pkg::ST_USER && i_write
      |=> !o_cs_q.prom2 && !o_cs_q.prom1)
      else $error("pseudo rom written during user run");
endmodule // map_switch_ctrl

// ===== sim/mcu_bus_model.sv
// mcu bus partner: paced bus cycles, fetch strobe, shared data bus
// assumes the bench calls cycle() from one process at a falling edge
`timescale 1ns/1ps
module mcu_bus_model (
   // clock
   input  wire logic        i_clk_sys,
   // block side of the data bus
   input  wire logic [7:0]  i_blk_data,
   input  wire logic        i_blk_oe_n,
   // bus toward the block
   output logic             o_bus_cyc,
   output logic             o_fetch,
   output logic             o_write,
   output logic [15:0]      o_addr,
   output logic [7:0]       o_data
);
   logic [7:0] drv_q;

   // block wins the data bus while it drives the trap opcode
   assign o_data = i_blk_oe_n ? drv_q : i_blk_data;

   initial begin
      o_bus_cyc = 1'b0;
      o_fetch = 1'b0;
      o_write = 1'b0;
      o_addr = 16'h0000;
      drv_q = 8'h00;
   end

   task automatic cycle(input logic f, input logic w, input logic [15:0] a,
                        input logic [7:0] d, input int gap);
      // one edge between cycles, so no signal is set twice in a step
      @(negedge i_clk_sys);
      o_fetch = f;
      o_write = w;
      o_addr = a;
      drv_q = d;
      repeat (gap + 1) @(negedge i_clk_sys);
      o_bus_cyc = 1'b1;
      @(negedge i_clk_sys);
      o_bus_cyc = 1'b0;
      o_fetch = 1'b0;
      // released bus must not keep its last value
      drv_q = ~d;
   endtask
endmodule // mcu_bus_model

// ===== sim/monitor_user_map_switch_control_test.sv
// self-checking bench for the map switch control
// assumes mcu_bus_model as the bus partner; one 100 MHz clock
`timescale 1ns/1ps
module monitor_user_map_switch_control_test;
   logic clk_sys = 1'b0, rst_n = 1'b0, temp_sw = 1'b0, perm_sw = 1'b0;
   logic brk = 1'b0, fam = 1'b0, abort_btn = 1'b0, ureset_btn = 1'b0;
   logic bus_cyc, fetch, wr, user_map, internal, mcu_rst_n, init_wp;
   logic blk_oe_n;
   logic [15:0] addr;
   logic [7:0] dbus, init_val, blk_data, iv, v;
   logic [16:0] cap;
   mapsw_pkg::cs_t cs;
   int seed = 32'hc5f6, num_errors = 0, checks = 0, n = 0, tmo = 0;
   logic [15:0] mon [8] = '{16'ha200, 16'ha20f, 16'ha210, 16'hb400,
                            16'hb5ff, 16'hb600, 16'hc000, 16'hffff};
   logic [15:0] usr [8] = '{16'hb600, 16'hb7ff, 16'hc000, 16'hdfff,
                            16'he000, 16'hffff, 16'ha200, 16'hb400};

   always #5 clk_sys = ~clk_sys;

   mcu_bus_model bm (.i_clk_sys(clk_sys), .i_blk_data(blk_data),
      .i_blk_oe_n(blk_oe_n), .o_bus_cyc(bus_cyc), .o_fetch(fetch),
      .o_write(wr), .o_addr(addr), .o_data(dbus));

   map_switch_ctrl uut (.i_clk_sys(clk_sys), .i_nrst(rst_n),
      .i_bus_cyc(bus_cyc), .i_instruction_fetch_strobe(fetch),
      .i_write(wr), .i_addr(addr), .i_data(dbus), .i_temp_switch(temp_sw),
      .i_perm_switch(perm_sw), .i_brk_armed(brk),
      .i_family_map_select(fam), .i_abort_pushbutton(abort_btn),
      .i_user_reset_pushbutton(ureset_btn), .o_user_map_q(user_map),
      .o_cs_q(cs), .o_internal_q(internal), .o_mcu_rst_n_q(mcu_rst_n),
      .o_init_wp_q(init_wp), .o_init_val_q(init_val), .o_data_q(blk_data),
      .o_data_oe_n_q(blk_oe_n));

   // what the block showed during each bus cycle
   always @(posedge clk_sys) begin
      if (bus_cyc) begin
         cap <= {user_map, cs, internal, blk_oe_n, dbus};
      end
      tmo++;
      if (tmo == 20000) begin
         $display("[FAIL] %0t timeout", $time);
         num_errors++;
         finish_test;
      end
   end

   task automatic finish_test;
      $display("TB: checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e,
                      input string m);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   function automatic logic exp_int(input logic [15:0] a);
      return a[15:8] == {iv[7:4], 4'h0} || a[15:6] == {iv[3:0], 6'h00};
   endfunction

   function automatic logic [5:0] exp_cs(input logic [15:0] a,
                                         input logic um, w, p);
      logic lock;
      lock = w & p;
      if (exp_int(a))
         return 6'h00;
      if (!um)
         return {a[15:4] == 12'ha20, a[15:9] == 7'h5a, a[15:14] == 2'b11,
                 3'b000};
      return {3'b000, a[15:9] == 7'h5b, fam & a[15:13] == 3'b110 & !lock,
              a[15:13] == 3'b111 & !lock};
   endfunction

   task automatic bc(input logic f, w, input logic [15:0] a,
                     input logic [7:0] d, input logic em, p);
      bm.cycle(f, w, a, d, 1 + 2 * ($random(seed) & 1));
      n++;
      chk(16'(cap[16]), 16'(em), "map");
      chk(16'(cap[15:10]), 16'(exp_cs(a, em, w, p)), "cs");
      chk(16'(cap[9]), 16'(exp_int(a)), "int");
   endtask

   task automatic stay(input int k, input logic em);
      repeat (k) bc(0, 0, 16'h2000, 8'($random(seed)), em, em);
   endtask

   task automatic press(input logic ab);
      abort_btn = ab;
      ureset_btn = !ab;
      repeat (6) @(negedge clk_sys);
      abort_btn = 1'b0;
      ureset_btn = 1'b0;
   endtask

   initial begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(16'(mcu_rst_n), 16'h1, "rst");
      chk(16'(init_wp), 16'h0, "wp");
      chk(16'(init_val), 16'h01, "init");
      iv = 8'h01;
      v = 8'($random(seed));
      bc(0, 1, {iv[3:0], 12'h03d}, v, 0, 0);
      iv = v;
      chk(16'(init_val), 16'(iv), "init");
      bc(0, 1, 16'h2000, ~iv, 0, 0);
      chk(16'(init_val), 16'(iv), "init");
      foreach (mon[i]) bc(0, 0, mon[i], 8'h00, 0, 0);
      bc(0, 0, {iv[7:4], 12'h0ff}, 8'h00, 0, 0);
      bc(0, 0, {iv[3:0], 12'h03f}, 8'h00, 0, 0);
      chk(16'(cap[9]), 16'h1, "internal");
      while (n < 63) stay(1, 0);
      chk(16'(init_wp), 16'h0, "wp");
      v = 8'($random(seed));
      bc(0, 1, {iv[3:0], 12'h03d}, v, 0, 0);
      iv = v;
      chk(16'(init_val), 16'(iv), "init");
      chk(16'(init_wp), 16'h1, "wp");
      bc(0, 1, {iv[3:0], 12'h03d}, ~v, 0, 0);
      chk(16'(init_val), 16'(iv), "init");
      $display("TB: init timeout done");
      fam = 1'($random(seed));
      temp_sw = 1'b1;
      @(negedge clk_sys);
      temp_sw = 1'b0;
      bc(1, 0, 16'hc100, 8'h86, 0, 0);
      stay(2, 0);
      bc(0, 1, fam ? 16'hc010 : 16'he010, 8'($random(seed)), 1, 0);
      stay(1, 0);
      $display("TB: temporary switch done");
      perm_sw = 1'b1;
      bc(1, 0, 16'hc200, 8'h3b, 0, 0);
      perm_sw = 1'b0;
      stay(3, 1);
      foreach (usr[i])
         bc(0, 1'($random(seed)), usr[i], 8'h5a, 1, 1);
      bc(1, 0, 16'he020, 8'h3f, 1, 1);
      stay(13, 1);
      press(1);
      bc(1, 0, 16'he030, 8'h12, 1, 1);
      chk(16'(cap[8]), 16'h0, "oe");
      chk(16'(cap[7:0]), 16'h3f, "opcode");
      stay(12, 1);
      stay(1, 0);
      $display("TB: abort done");
      press(1);
      bc(1, 0, 16'hc000, 8'h01, 0, 0);
      chk(16'(cap[8]), 16'h1, "oe");
      perm_sw = 1'b1;
      bc(1, 0, 16'hc200, 8'h3b, 0, 0);
      perm_sw = 1'b0;
      bc(1, 0, 16'he000, 8'h01, 1, 1);
      chk(16'(cap[8]), 16'h1, "oe");
      brk = 1'b1;
      bc(1, 0, 16'he040, 8'h3f, 1, 1);
      stay(12, 1);
      stay(1, 0);
      $display("TB: breakpoint done");
      press(0);
      chk(16'(mcu_rst_n), 16'h0, "rst");
      chk(16'(user_map), 16'h1, "map");
      chk(16'(init_wp), 16'h0, "wp");
      // button release takes four clocks through the synchroniser
      repeat (5) @(negedge clk_sys);
      chk(16'(mcu_rst_n), 16'h1, "rst");
      bc(0, 0, 16'hfffe, 8'he0, 1, 1);
      bc(1, 0, 16'he050, 8'h3f, 1, 1);
      stay(13, 1);
      $display("TB: user reset done");
      finish_test;
   end
endmodule // monitor_user_map_switch_control_test
